// ===== common/sts_map.svh
`ifndef STS_MAP_SVH
`define STS_MAP_SVH
`define STS_TAG_W 16
`define STS_XTAG_W 16
`define STS_LEN_W 24
`define STS_ADDR_W 64
`define STS_RTY_W 4
`define STS_FIFO_DEPTH 8
`define STS_TAG_RST 16'h0000
`define STS_OFS_RST 24'h000000
`define STS_RTY_RST 4'h0
`endif

// ===== common/sts_pkg.sv
`include "sts_map.svh"
package sts_pkg;
   typedef enum logic [1:0] {STS_FR_DATA, STS_FR_XFER, STS_FR_RESP} sts_frame_t;
   typedef enum logic [2:0] {STS_ST_XMIT, STS_ST_ACK, STS_ST_NAK, STS_ST_TMO, STS_ST_LOST,
                             STS_ST_CANACK, STS_ST_NEXUS, STS_ST_OTHER} sts_status_t;
   typedef enum logic [3:0] {STS_TC_XFER_OK, STS_TC_RESP_OK, STS_TC_DIN_OK, STS_TC_RESP_FAIL,
                             STS_TC_XFER_NAK, STS_TC_XFER_CONN, STS_TC_DIN_NAK, STS_TC_DIN_CONN,
                             STS_TC_TERM, STS_TC_NEXUS, STS_TC_OTHER} sts_tc_t;
   typedef enum logic [1:0] {STS_NX_START, STS_NX_DIN, STS_NX_WDATA} sts_next_t;
   typedef struct packed {
      sts_frame_t kind;
      logic cancel;
      logic [`STS_LEN_W-1:0] len;
      logic [`STS_TAG_W-1:0] tag;
      logic [`STS_ADDR_W-1:0] dest;
   } sts_entry_t;
   typedef struct packed {
      sts_frame_t kind;
      logic interlocked;
      logic resend;
      logic [`STS_XTAG_W-1:0] xfer_tag;
      logic [`STS_LEN_W-1:0] len;
      logic [`STS_TAG_W-1:0] tag;
      logic [`STS_ADDR_W-1:0] dest;
   } sts_tx_t;
   typedef struct packed {
      sts_tc_t code;
      logic [`STS_ADDR_W-1:0] dest;
      logic [`STS_TAG_W-1:0] tag;
      logic [`STS_XTAG_W-1:0] xfer_tag;
   } sts_tc_msg_t;
endpackage : sts_pkg

// ===== design/sts_frame_send.sv
// Contract
// - A retried transfer-ready frame goes out with its resend flag set.
// - A retried transfer-ready frame gets a transfer tag unlike previous and in-use tags.
// - Write data for a later transfer-ready frame frees all earlier tags of the command.
// - A transfer-ready retry issues a new interlocked transmit request with the frame.
// - Ack on transfer-ready reports it delivered, with the transfer tag used.
// - Ack on a response frame reports the response delivered.
// - Read data delivered only when offset equals byte count and balance point.
// - Response failure after the retry limit reports response failed.
// - Transfer-ready failure without retry reports a NAK or a connection cause.
// - Read data failure without retry reports a NAK or a connection cause.
// - Cancel with nothing outstanding reports data transfer terminated.
// - Cancel with requests outstanding sends a cancel request with address and tag.
// - Cancel acknowledged from the port layer then reports data transfer terminated.
// - Every completion message carries destination address and tag.
// - Any completion other than transfer-ready delivered returns to the start state.
// - Read frame sent with offset below byte count goes to build the next one.
// - Retriable read frame failure goes to data-in preparation with a retry mark.
// - After transfer-ready delivered, move on to receiving write data.
// - After interlocked frame transmitted, wait for ack, nak, timeout or lost link.
// - Each read frame ack seen in a wait state advances the balance point by that frame's bytes; the completing ack clears it.
module sts_frame_send
   import sts_pkg::*;
#(
   parameter int DEPTH = `STS_FIFO_DEPTH
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Entry from the frame-building states
   input wire logic entry_valid,
   input wire sts_entry_t entry,
   input wire logic cancel_msg,
   // Configuration and command context
   input wire logic retry_en,
   input wire logic [`STS_RTY_W-1:0] retry_limit,
   input wire logic [`STS_LEN_W-1:0] din_byte_count,
   input wire logic write_data_arrived,
   // Port layer
   output logic tx_valid,
   output sts_tx_t tx,
   output logic cancel_req,
   input wire logic conf_valid,
   input wire sts_status_t conf,
   // Transfer manager
   output logic tc_valid,
   output sts_tc_msg_t tc,
   // Next state selection
   output logic nx_valid,
   output sts_next_t nx,
   output logic nx_retry,
   // Status
   output logic busy,
   output logic [`STS_LEN_W-1:0] read_offset,
   output logic [`STS_LEN_W-1:0] balance_offset,
   output logic [`STS_XTAG_W-1:0] tags_in_use
);
   localparam int PW = $clog2(DEPTH);

   typedef enum logic [1:0] {S_IDLE, S_WAIT_TX, S_WAIT_ACK, S_CANCEL} sts_state_t;

   sts_state_t state;
   sts_state_t next_state;
   sts_entry_t cur;
   sts_entry_t ctx;
   sts_tx_t next_tx;
   sts_tc_msg_t next_tc;
   sts_next_t next_nx;
   sts_tc_t fin_code;
   sts_next_t fin_nx;
   logic next_tx_valid, next_cancel_req, next_tc_valid, next_nx_valid, next_nx_retry;
   logic fin, do_push, do_pop, do_rewind, do_retry, do_alloc, do_start, done;
   logic in_wait, fail_conf, can_retry, cancel_hit;
   logic [`STS_RTY_W-1:0] retry_cnt;
   logic [`STS_XTAG_W-1:0] alloc_tag;
   logic [`STS_XTAG_W-1:0] in_use_lo;
   logic [`STS_LEN_W-1:0] len_mem [DEPTH];
   logic [`STS_LEN_W-1:0] new_offset;
   logic [`STS_LEN_W-1:0] new_balance;
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [PW:0] out_cnt;

   function automatic logic [`STS_LEN_W-1:0] add_len(input logic [`STS_LEN_W-1:0] a,
                                                     input logic [`STS_LEN_W-1:0] b);
      return a + b;
   endfunction : add_len

   function automatic sts_tc_t fail_code(input sts_frame_t k, input sts_status_t s);
      if (k == STS_FR_RESP)
         return STS_TC_RESP_FAIL;
      else if (k == STS_FR_XFER)
         return (s == STS_ST_NAK) ? STS_TC_XFER_NAK : STS_TC_XFER_CONN;
      else
         return (s == STS_ST_NAK) ? STS_TC_DIN_NAK : STS_TC_DIN_CONN;
   endfunction : fail_code

   assign in_wait = (state == S_WAIT_TX) || (state == S_WAIT_ACK);
   assign fail_conf = (conf == STS_ST_NAK) || (conf == STS_ST_TMO) || (conf == STS_ST_LOST);
   assign can_retry = retry_en && (retry_cnt < retry_limit);
   assign ctx = (state == S_IDLE) ? entry : cur;
   assign cancel_hit = (state == S_IDLE && entry_valid && entry.cancel) || (in_wait && cancel_msg);
   assign new_offset = add_len(read_offset, cur.len);
   assign new_balance = add_len(balance_offset, len_mem[rd_ptr]);
   assign do_start = fin && (fin_nx == STS_NX_START);
   assign done = in_wait && conf_valid && !cancel_hit && ((conf == STS_ST_ACK) || fail_conf);

   always_comb
   begin
      next_state = state;
      next_tx_valid = 1'b0;
      next_tx = tx;
      next_cancel_req = 1'b0;
      next_tc_valid = 1'b0;
      next_tc = tc;
      next_nx_valid = 1'b0;
      next_nx = nx;
      next_nx_retry = 1'b0;
      fin = 1'b0;
      fin_code = STS_TC_OTHER;
      fin_nx = STS_NX_START;
      do_push = 1'b0;
      do_pop = 1'b0;
      do_rewind = 1'b0;
      do_retry = 1'b0;
      do_alloc = 1'b0;
      if (cancel_hit)
      begin
         if (out_cnt == '0)
         begin
            fin = 1'b1;
            fin_code = STS_TC_TERM;
         end
         else
         begin
            next_cancel_req = 1'b1;
            next_tx.dest = ctx.dest;
            next_tx.tag = ctx.tag;
            next_state = S_CANCEL;
         end
      end
      else
         case (state)
            S_IDLE:
               if (entry_valid)
               begin
                  next_tx_valid = 1'b1;
                  next_tx.kind = entry.kind;
                  next_tx.interlocked = (entry.kind != STS_FR_DATA);
                  next_tx.resend = 1'b0;
                  next_tx.xfer_tag = (entry.kind == STS_FR_XFER) ? alloc_tag + 1'b1 : `STS_TAG_RST;
                  next_tx.len = entry.len;
                  next_tx.tag = entry.tag;
                  next_tx.dest = entry.dest;
                  do_alloc = (entry.kind == STS_FR_XFER);
                  next_state = S_WAIT_TX;
               end
            S_WAIT_TX, S_WAIT_ACK:
               if (conf_valid)
                  case (conf)
                     STS_ST_XMIT:
                        if (cur.kind == STS_FR_DATA && state == S_WAIT_TX)
                        begin
                           do_push = 1'b1;
                           if (new_offset < din_byte_count)
                           begin
                              next_nx_valid = 1'b1;
                              next_nx = STS_NX_DIN;
                              next_state = S_IDLE;
                           end
                           else
                              next_state = S_WAIT_ACK;
                        end
                        else
                           next_state = S_WAIT_ACK;
                     STS_ST_ACK:
                        if (cur.kind == STS_FR_XFER)
                        begin
                           fin = 1'b1;
                           fin_code = STS_TC_XFER_OK;
                           fin_nx = STS_NX_WDATA;
                        end
                        else if (cur.kind == STS_FR_RESP)
                        begin
                           fin = 1'b1;
                           fin_code = STS_TC_RESP_OK;
                        end
                        else
                        begin
                           do_pop = 1'b1;
                           if (new_balance == read_offset && read_offset == din_byte_count)
                           begin
                              fin = 1'b1;
                              fin_code = STS_TC_DIN_OK;
                           end
                        end
                     STS_ST_NAK, STS_ST_TMO, STS_ST_LOST:
                        if (can_retry)
                        begin
                           do_retry = 1'b1;
                           if (cur.kind == STS_FR_DATA)
                           begin
                              do_rewind = 1'b1;
                              next_nx_valid = 1'b1;
                              next_nx = STS_NX_DIN;
                              next_nx_retry = 1'b1;
                              next_state = S_IDLE;
                           end
                           else
                           begin
                              next_tx_valid = 1'b1;
                              next_tx.resend = 1'b1;
                              if (cur.kind == STS_FR_XFER)
                              begin
                                 next_tx.xfer_tag = alloc_tag + 1'b1;
                                 do_alloc = 1'b1;
                              end
                              next_state = S_WAIT_TX;
                           end
                        end
                        else
                        begin
                           fin = 1'b1;
                           fin_code = fail_code(cur.kind, conf);
                        end
                     STS_ST_NEXUS:
                     begin
                        fin = 1'b1;
                        fin_code = STS_TC_NEXUS;
                     end
                     default:
                        fin = 1'b1;
                  endcase
            S_CANCEL:
               if (conf_valid && conf == STS_ST_CANACK)
               begin
                  fin = 1'b1;
                  fin_code = STS_TC_TERM;
               end
            default:
               next_state = S_IDLE;
         endcase
      if (fin)
      begin
         next_tc_valid = 1'b1;
         next_tc = '{code: fin_code, dest: ctx.dest, tag: ctx.tag, xfer_tag: tx.xfer_tag};
         next_nx_valid = 1'b1;
         next_nx = fin_nx;
         next_state = S_IDLE;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state <= S_IDLE;
         tx_valid <= 1'b0;
         tx <= '0;
         cancel_req <= 1'b0;
         tc_valid <= 1'b0;
         tc <= '0;
         nx_valid <= 1'b0;
         nx <= STS_NX_START;
         nx_retry <= 1'b0;
         busy <= 1'b0;
         cur <= '0;
      end
      else
      begin
         state <= next_state;
         tx_valid <= next_tx_valid;
         tx <= next_tx;
         cancel_req <= next_cancel_req;
         tc_valid <= next_tc_valid;
         tc <= next_tc;
         nx_valid <= next_nx_valid;
         nx <= next_nx;
         nx_retry <= next_nx_retry;
         busy <= (next_state != S_IDLE);
         if (state == S_IDLE && entry_valid)
            cur <= entry;
      end
   end

   // Retry budget restarts once a frame is acknowledged or the exchange ends
   always_ff @(posedge clk)
   begin
      if (sys_rst || fin || do_pop)
         retry_cnt <= `STS_RTY_RST;
      else if (do_retry)
         retry_cnt <= retry_cnt + 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst || do_start)
      begin
         read_offset <= `STS_OFS_RST;
         balance_offset <= `STS_OFS_RST;
      end
      else
      begin
         if (do_rewind)
            read_offset <= balance_offset;
         else if (do_push)
            read_offset <= new_offset;
         if (do_pop)
            balance_offset <= new_balance;
      end
   end

   // Lengths of sent read frames still awaiting their ack
   always_ff @(posedge clk)
   begin
      if (do_push)
         len_mem[wr_ptr] <= cur.len;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst || do_start || do_rewind)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         out_cnt <= '0;
      end
      else
      begin
         if (do_push)
            wr_ptr <= wr_ptr + 1'b1;
         if (do_pop)
            rd_ptr <= rd_ptr + 1'b1;
         out_cnt <= out_cnt + (PW+1)'(next_tx_valid) - (PW+1)'(done);
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         alloc_tag <= `STS_TAG_RST;
         in_use_lo <= `STS_TAG_RST;
         tags_in_use <= `STS_TAG_RST;
      end
      else
      begin
         if (do_alloc)
            alloc_tag <= alloc_tag + 1'b1;
         if (write_data_arrived)
            in_use_lo <= alloc_tag;
         tags_in_use <= alloc_tag - in_use_lo;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   logic ack_now, fail_now;
   assign ack_now = in_wait && conf_valid && !cancel_hit && conf == STS_ST_ACK;
   assign fail_now = in_wait && conf_valid && !cancel_hit && fail_conf;

   chk_xfer_resend: assert property (fail_now && can_retry && cur.kind == STS_FR_XFER |=>
      tx_valid && tx.resend && tx.interlocked && state == S_WAIT_TX) else $error("xfer retry not resent");
   chk_xfer_new_tag: assert property (fail_now && can_retry && cur.kind == STS_FR_XFER |=>
      tx.xfer_tag != $past(tx.xfer_tag) && tx.xfer_tag != in_use_lo) else $error("xfer tag reused");
   chk_tag_free: assert property (write_data_arrived && !do_alloc |=> ##1
      tags_in_use == '0) else $error("tags not freed");
   chk_xfer_done: assert property (ack_now && cur.kind == STS_FR_XFER |=> tc_valid && tc.code == STS_TC_XFER_OK
      && tc.xfer_tag == tx.xfer_tag && nx == STS_NX_WDATA && state == S_IDLE) else $error("xfer ok wrong");
   chk_resp_done: assert property (ack_now && cur.kind == STS_FR_RESP |=> tc_valid &&
      tc.code == STS_TC_RESP_OK && nx_valid && nx == STS_NX_START) else $error("resp ok wrong");
   chk_din_done: assert property (tc_valid && tc.code == STS_TC_DIN_OK |->
      $past(read_offset) == $past(din_byte_count) && read_offset == '0) else $error("din ok early");
   chk_fail_cause: assert property (fail_now && !can_retry |=> tc_valid &&
      tc.code == fail_code($past(cur.kind), $past(conf))) else $error("fail cause wrong");
   chk_cancel_idle: assert property (cancel_hit && out_cnt == '0 |=> tc_valid &&
      tc.code == STS_TC_TERM && !cancel_req) else $error("cancel not terminated");
   chk_cancel_req: assert property (cancel_hit && out_cnt != '0 |=> cancel_req &&
      state == S_CANCEL && !tc_valid ##1 !cancel_req) else $error("cancel request missing");
   chk_cancel_ack: assert property (state == S_CANCEL && conf_valid && conf == STS_ST_CANACK |=>
      tc_valid && tc.code == STS_TC_TERM) else $error("cancel ack not reported");
   chk_tc_args: assert property (tc_valid |-> tc.tag == $past(ctx.tag) &&
      tc.dest == $past(ctx.dest)) else $error("completion args wrong");
   chk_din_next: assert property (state == S_WAIT_TX && conf_valid && !cancel_hit && conf == STS_ST_XMIT
      && cur.kind == STS_FR_DATA && new_offset < din_byte_count |=> nx_valid && nx == STS_NX_DIN && !nx_retry)
      else $error("din continue wrong");
   chk_din_retry: assert property (fail_now && can_retry && cur.kind == STS_FR_DATA |=>
      nx_valid && nx_retry && read_offset == balance_offset) else $error("din retry wrong");
   chk_wait_ack: assert property (state == S_WAIT_TX && conf_valid && !cancel_hit && conf == STS_ST_XMIT
      && cur.kind != STS_FR_DATA |=> state == S_WAIT_ACK && !tc_valid) else $error("no ack wait");
   chk_balance_step: assert property (do_pop && !do_start |=>
      balance_offset == $past(new_balance)) else $error("balance not advanced");
   chk_retry_bound: assert property (do_retry |-> retry_en && retry_cnt < retry_limit ##1
      retry_cnt == $past(retry_cnt) + 4'h1) else $error("retry beyond limit");

   cov_xfer_ok: cover property (tc_valid && tc.code == STS_TC_XFER_OK);
   cov_din_ok: cover property (tc_valid && tc.code == STS_TC_DIN_OK);
   cov_resp_retry: cover property (tx_valid && tx.resend && tx.kind == STS_FR_RESP);
   cov_cancel_ack: cover property (state == S_CANCEL ##1 tc_valid);
endmodule : sts_frame_send

// ===== test/sts_frame_send_test.sv
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
   $display("CHECK FAILED at %0t: got %h expected %h", $time, (a), (b)); end end

module sts_frame_send_test
   import sts_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] TAG = 16'h00a5;
   localparam logic [63:0] DST = 64'h5000_0000_0000_0001;
   logic clk, sys_rst, entry_valid, cancel_msg, retry_en, write_data_arrived;
   logic tx_valid, cancel_req, conf_valid, tc_valid, nx_valid, nx_retry, busy;
   logic [3:0] retry_limit, dly;
   logic [1:0] fcnt;
   logic [23:0] din_byte_count, read_offset, balance_offset;
   logic [15:0] tags_in_use, x;
   sts_entry_t entry;
   sts_tx_t tx;
   sts_status_t conf, fcode;
   sts_tc_msg_t tc;
   sts_next_t nx;
   int error_cnt, comparisons, cyc;

   sts_frame_send #(.DEPTH(8)) sts_frame_send_inst (.clk(clk), .sys_rst(sys_rst), .entry_valid(entry_valid),
      .entry(entry), .cancel_msg(cancel_msg), .retry_en(retry_en), .retry_limit(retry_limit),
      .din_byte_count(din_byte_count), .write_data_arrived(write_data_arrived), .tx_valid(tx_valid), .tx(tx),
      .cancel_req(cancel_req), .conf_valid(conf_valid), .conf(conf), .tc_valid(tc_valid), .tc(tc),
      .nx_valid(nx_valid), .nx(nx), .nx_retry(nx_retry), .busy(busy), .read_offset(read_offset),
      .balance_offset(balance_offset), .tags_in_use(tags_in_use));

   sts_port_model sts_port_model_inst (.clk(clk), .sys_rst(sys_rst), .tx_valid(tx_valid),
      .cancel_req(cancel_req), .dly(dly), .fin_code(fcode), .fin_cnt(fcnt), .conf_valid(conf_valid), .conf(conf));

   always #10 clk = ~clk;

   task test_done();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : test_done

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         test_done();
      end
   end

   task cfg(input logic r, input logic [3:0] d, input sts_status_t c, input logic [1:0] n);
      @(negedge clk);
      retry_en = r;
      dly = d;
      fcode = c;
      fcnt = n;
   endtask : cfg

   task send(input sts_frame_t k, input logic c, input logic [23:0] l);
      @(negedge clk);
      entry_valid = 1'b1;
      entry = '{k, c, l, TAG, DST};
      @(negedge clk);
      entry_valid = 1'b0;
   endtask : send

   // 0 frame request, 1 completion, 2 cancel request, 3 next state, 4 ack on the wire
   task wait_for(input int w);
      int i;
      for (i = 0; i < 60; i++)
      begin
         if ((w == 0 && tx_valid === 1'b1) || (w == 1 && tc_valid === 1'b1) || (w == 2 && cancel_req === 1'b1)
             || (w == 3 && nx_valid === 1'b1) || (w == 4 && conf_valid === 1'b1 && conf === STS_ST_ACK))
            break;
         @(posedge clk);
         #1;
      end
      `CHK(i < 60, 1'b1)
   endtask : wait_for

   task fin(input sts_tc_t c, input sts_next_t n);
      wait_for(1);
      `CHK(tc.code, c)
      `CHK(tc.dest, DST)
      `CHK(tc.tag, TAG)
      wait_for(3);
      `CHK(nx, n)
      `CHK(busy, 1'b0)
   endtask : fin

   task t_xfer();
      cfg(1'b0, 4'h1, STS_ST_ACK, 2'h1);
      send(STS_FR_XFER, 1'b0, 24'h0);
      wait_for(0);
      x = tx.xfer_tag;
      `CHK(busy, 1'b1)
      fin(STS_TC_XFER_OK, STS_NX_WDATA);
      `CHK(tc.xfer_tag, x)
      `CHK(tags_in_use, 16'h0001)
      @(negedge clk);
      write_data_arrived = 1'b1;
      @(negedge clk);
      write_data_arrived = 1'b0;
      cfg(1'b0, 4'h0, STS_ST_ACK, 2'h1);
      `CHK(tags_in_use, 16'h0000)
      send(STS_FR_RESP, 1'b0, 24'h0);
      fin(STS_TC_RESP_OK, STS_NX_START);
      $display("delivery test done");
   endtask : t_xfer

   task t_xretry();
      cfg(1'b1, 4'h2, STS_ST_NAK, 2'h1);
      send(STS_FR_XFER, 1'b0, 24'h0);
      wait_for(0);
      x = tx.xfer_tag;
      @(posedge clk);
      #1;
      wait_for(0);
      `CHK(tx.resend, 1'b1)
      `CHK(tx.interlocked, 1'b1)
      `CHK(tx.xfer_tag != x, 1'b1)
      fin(STS_TC_XFER_NAK, STS_NX_START);
      cfg(1'b0, 4'h0, STS_ST_TMO, 2'h1);
      send(STS_FR_XFER, 1'b0, 24'h0);
      fin(STS_TC_XFER_CONN, STS_NX_START);
      cfg(1'b1, 4'h1, STS_ST_TMO, 2'h1);
      send(STS_FR_RESP, 1'b0, 24'h0);
      fin(STS_TC_RESP_FAIL, STS_NX_START);
      $display("retry test done");
   endtask : t_xretry

   task t_din();
      cfg(1'b0, 4'h0, STS_ST_ACK, 2'h0);
      din_byte_count = 24'h000080;
      send(STS_FR_DATA, 1'b0, 24'h000040);
      wait_for(3);
      `CHK(nx, STS_NX_DIN)
      `CHK(nx_retry, 1'b0)
      `CHK(read_offset, 24'h000040)
      cfg(1'b0, 4'h3, STS_ST_ACK, 2'h2);
      send(STS_FR_DATA, 1'b0, 24'h000040);
      wait_for(4);
      @(posedge clk);
      #1;
      `CHK(balance_offset, 24'h000040)
      `CHK(tc_valid, 1'b0)
      fin(STS_TC_DIN_OK, STS_NX_START);
      $display("read data test done");
   endtask : t_din

   task t_dfail();
      cfg(1'b1, 4'h1, STS_ST_NAK, 2'h1);
      din_byte_count = 24'h000040;
      send(STS_FR_DATA, 1'b0, 24'h000040);
      wait_for(3);
      `CHK(nx, STS_NX_DIN)
      `CHK(nx_retry, 1'b1)
      send(STS_FR_DATA, 1'b0, 24'h000040);
      fin(STS_TC_DIN_NAK, STS_NX_START);
      cfg(1'b0, 4'h1, STS_ST_LOST, 2'h1);
      send(STS_FR_DATA, 1'b0, 24'h000040);
      fin(STS_TC_DIN_CONN, STS_NX_START);
      $display("read failure test done");
   endtask : t_dfail

   task t_cancel();
      send(STS_FR_DATA, 1'b1, 24'h0);
      fin(STS_TC_TERM, STS_NX_START);
      cfg(1'b0, 4'h0, STS_ST_NEXUS, 2'h1);
      send(STS_FR_RESP, 1'b0, 24'h0);
      fin(STS_TC_NEXUS, STS_NX_START);
      cfg(1'b0, 4'h8, STS_ST_ACK, 2'h1);
      send(STS_FR_XFER, 1'b0, 24'h0);
      @(negedge clk);
      cancel_msg = 1'b1;
      @(negedge clk);
      cancel_msg = 1'b0;
      wait_for(2);
      `CHK(tx.dest, DST)
      `CHK(tx.tag, TAG)
      fin(STS_TC_TERM, STS_NX_START);
      $display("cancel test done");
   endtask : t_cancel

   initial
   begin
      clk = 1'b0;
      sys_rst = 1'b1;
      entry_valid = 1'b0;
      entry = '{STS_FR_DATA, 1'b0, 24'h0, TAG, DST};
      cancel_msg = 1'b0;
      retry_en = 1'b0;
      retry_limit = 4'h1;
      din_byte_count = 24'h0;
      write_data_arrived = 1'b0;
      dly = 4'h0;
      fcode = STS_ST_ACK;
      fcnt = 2'h1;
      repeat (3) @(negedge clk);
      sys_rst = 1'b0;
      t_xfer();
      t_xretry();
      t_din();
      t_dfail();
      t_cancel();
      test_done();
   end
endmodule : sts_frame_send_test

// ===== test/sts_port_model.sv
module sts_port_model
   import sts_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Requests from the send state
   input wire logic tx_valid,
   input wire logic cancel_req,
   // Reply settings
   input wire logic [3:0] dly,
   input wire sts_status_t fin_code,
   input wire logic [1:0] fin_cnt,
   // Confirmations
   output logic conf_valid,
   output sts_status_t conf
);
   logic [1:0] phase;
   logic [3:0] cnt;
   logic [1:0] left;

   always @(negedge clk)
   begin
      conf_valid <= 1'b0;
      // Idle code keeps moving so a stale code never looks like a reply
      conf <= sts_status_t'(conf + 3'h1);
      if (sys_rst)
      begin
         phase <= 2'h0;
         conf <= STS_ST_OTHER;
      end
      else if (cancel_req)
      begin
         phase <= 2'h3;
         cnt <= dly;
      end
      else if (tx_valid)
      begin
         phase <= 2'h1;
         cnt <= dly;
      end
      else if (phase != 2'h0)
      begin
         if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
         else
         begin
            conf_valid <= 1'b1;
            cnt <= dly;
            case (phase)
               2'h1:
               begin
                  conf <= STS_ST_XMIT;
                  phase <= (fin_cnt != 2'h0) ? 2'h2 : 2'h0;
                  left <= fin_cnt;
               end
               2'h2:
               begin
                  conf <= fin_code;
                  left <= left - 2'h1;
                  phase <= (left == 2'h1) ? 2'h0 : 2'h2;
               end
               default:
               begin
                  conf <= STS_ST_CANACK;
                  phase <= 2'h0;
               end
            endcase
         end
      end
   end
endmodule : sts_port_model
